// ===== rtl/dcfs_map.svh
// Address map, field positions and erased values of the configuration store.
`ifndef DCFS_MAP_SVH
`define DCFS_MAP_SVH
`define DCFS_ADDR_OSC       24'hF8_0000
`define DCFS_ADDR_WDT       24'hF8_0002
`define DCFS_ADDR_BOR       24'hF8_0004
`define DCFS_ADDR_CODE      24'hF8_000A
`define DCFS_ERASED         16'hFFFF
`define DCFS_BOR_IMPL_MASK  16'h87B3
`define DCFS_BIT_RESET_PIN  15
`define DCFS_BIT_PWM_MODE   10
`define DCFS_BIT_HIGH_POL   9
`define DCFS_BIT_LOW_POL    8
`define DCFS_BIT_BOR_EN     7
`define DCFS_BROWNOUT_TRIP_SELECT_HI        5
`define DCFS_BROWNOUT_TRIP_SELECT_LO        4
`define DCFS_POWERON_DELAY_TIMER_HI        1
`define DCFS_POWERON_DELAY_TIMER_LO        0
`endif

// ===== rtl/dcfs_pkg.sv
// Types shared by the configuration store.
`default_nettype none
package dcfs_pkg;
  typedef enum logic [2:0] {
    DCFS_LOAD  = 3'b001,
    DCFS_IDLE  = 3'b010,
    DCFS_WRITE = 3'b100
  } dcfs_state_t;
  typedef enum logic [1:0] {
    DCFS_SRC_SELF   = 2'b00,
    DCFS_SRC_SERIAL = 2'b01,
    DCFS_SRC_EXTERN = 2'b10
  } dcfs_src_t;
endpackage
`default_nettype wire

// ===== rtl/dcfs_store.sv
// Device configuration store with program-space read and three write sources.
// Function
// - Words kept nonvolatile; survive power cycles.
// - Words mapped from 0xF80000; readable while running.
// - Words are 24 bits; low 16 hold data.
// - Programmed bit reads zero; erased reads one.
// - Four words at F80000, F80002, F80004, F8000A.
// - Writes from self, serial port, external programmer.
// - Bit 15 one enables external reset input.
// - Bit 10 selects PWM pin reset ownership.
// - Bits 9, 8 set high/low side polarity.
// - Brown-out trip select and enable bit.
// - Bits 1..0 select power-on delay.
`include "dcfs_map.svh"
`default_nettype none
module dcfs_store (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        rd_req,
  input  wire logic [23:0] rd_addr,
  output var  logic        rd_valid,
  output var  logic [23:0] rd_data,
  input  wire logic        wr_req,
  input  wire logic [1:0]  wr_src,
  input  wire logic [23:0] wr_addr,
  input  wire logic [15:0] wr_data,
  output var  logic        wr_done,
  output var  logic        reset_pin_enable,
  output var  logic        pwm_pin_reset_mode,
  output var  logic        high_side_polarity,
  output var  logic        low_side_polarity,
  output var  logic        brownout_reset_enable,
  output var  logic [1:0]  brownout_trip_select,
  output var  logic [1:0]  poweron_delay_select
);
  // Nonvolatile cells: never touched by reset, so contents persist.
  logic [15:0]           nv_cell [0:3] = '{default: `DCFS_ERASED};
  dcfs_pkg::dcfs_state_t state_reg;
  logic [15:0]           bor_word;
  logic [2:0]            wr_index;
  logic [2:0]            rd_index;
  logic [15:0]           wr_cell;

  // Maps a program-space address to a word index, or flags a miss.
  function automatic logic [2:0] word_index(input logic [23:0] addr);
    case (addr)
      `DCFS_ADDR_OSC:  word_index = 3'h4;
      `DCFS_ADDR_WDT:  word_index = 3'h5;
      `DCFS_ADDR_BOR:  word_index = 3'h6;
      `DCFS_ADDR_CODE: word_index = 3'h7;
      default:         word_index = 3'h0;
    endcase
  endfunction

  // Stored value with unimplemented bits forced low for reading.
  function automatic logic [15:0] visible(input logic [1:0] idx, input logic [15:0] w);
    visible = (idx == 2'd2) ? (w & `DCFS_BOR_IMPL_MASK) : w;
  endfunction

  assign bor_word = nv_cell[2];

  // Each bus address is decoded once; bit 2 of an index flags a mapped word.
  assign wr_index = word_index(wr_addr);
  assign rd_index = word_index(rd_addr);
  assign wr_cell  = nv_cell[wr_index[1:0]];

  // Load runs for one cycle after reset, then idle and write alternate.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= dcfs_pkg::DCFS_LOAD;
    end else begin
      case (state_reg)
        dcfs_pkg::DCFS_LOAD:  state_reg <= dcfs_pkg::DCFS_IDLE;
        dcfs_pkg::DCFS_IDLE:  state_reg <= wr_req ? dcfs_pkg::DCFS_WRITE : dcfs_pkg::DCFS_IDLE;
        dcfs_pkg::DCFS_WRITE: state_reg <= dcfs_pkg::DCFS_IDLE;
        default:              state_reg <= dcfs_pkg::DCFS_LOAD;
      endcase
    end
  end

  // Programming clears bits only; erased cells hold all ones.
  // Erase is not modelled, so a cell can only lose ones; reset never restores them.
  always_ff @(posedge core_clk) begin
    if (state_reg == dcfs_pkg::DCFS_IDLE && wr_req && wr_index[2]
        && wr_src != 2'b11) begin
      nv_cell[wr_index[1:0]] <= wr_cell & wr_data;
    end
  end

  // The done pulse follows the write state by one cycle.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_done <= 1'b0;
    end else begin
      wr_done <= (state_reg == dcfs_pkg::DCFS_WRITE);
    end
  end

  // Reads answer one cycle later; upper byte zero, misses read zero.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
      rd_data  <= 24'h00_0000;
    end else begin
      rd_valid <= rd_req;
      if (rd_req && rd_index[2]) begin
        rd_data <= {8'h00, visible(rd_index[1:0], nv_cell[rd_index[1:0]])};
      end else begin
        rd_data <= 24'h00_0000;
      end
    end
  end

  // Settings are applied at device reset, from the load state.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reset_pin_enable      <= 1'b1;
      pwm_pin_reset_mode    <= 1'b1;
      high_side_polarity    <= 1'b1;
      low_side_polarity     <= 1'b1;
      brownout_reset_enable <= 1'b1;
      brownout_trip_select  <= 2'b11;
      poweron_delay_select  <= 2'b11;
    end else if (state_reg == dcfs_pkg::DCFS_LOAD) begin
      reset_pin_enable      <= bor_word[`DCFS_BIT_RESET_PIN];
      pwm_pin_reset_mode    <= bor_word[`DCFS_BIT_PWM_MODE];
      high_side_polarity    <= bor_word[`DCFS_BIT_HIGH_POL];
      low_side_polarity     <= bor_word[`DCFS_BIT_LOW_POL];
      brownout_reset_enable <= bor_word[`DCFS_BIT_BOR_EN];
      brownout_trip_select  <= bor_word[`DCFS_BROWNOUT_TRIP_SELECT_HI:`DCFS_BROWNOUT_TRIP_SELECT_LO];
      poweron_delay_select  <= bor_word[`DCFS_POWERON_DELAY_TIMER_HI:`DCFS_POWERON_DELAY_TIMER_LO];
    end
  end

  // Read bus: one-cycle answer, zero data when idle or unmapped.
  read_latency_a: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_req |=> rd_valid)
    else $error("read answer missing one cycle after request");
  read_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !rd_req |=> (!rd_valid && rd_data == 24'h00_0000))
    else $error("read answer without a request");
  code_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_req && rd_addr == `DCFS_ADDR_CODE) |=> rd_data[15:0] == $past(nv_cell[3]))
    else $error("code segment word read back wrong");
  upper_byte_a: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_valid |-> rd_data[23:16] == 8'h00)
    else $error("upper byte of a read is not zero");
  unmapped_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_req && !rd_index[2]) |=> rd_data == 24'h00_0000)
    else $error("unmapped read returned data");
  bor_reserved_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_req && rd_addr == `DCFS_ADDR_BOR)
      |=> (rd_data[14:11] == 4'h0 && rd_data[6] == 1'b0 && rd_data[3:2] == 2'h0))
    else $error("reserved bits of brown-out word read nonzero");

  // Write walk: taken in idle, one cycle in the write state, then the done pulse.
  sequence write_taken_s;
    state_reg == dcfs_pkg::DCFS_IDLE && wr_req;
  endsequence
  sequence write_walk_s;
    state_reg == dcfs_pkg::DCFS_WRITE && !wr_done ##1 wr_done;
  endsequence
  write_done_a: assert property (@(posedge core_clk) disable iff (!resetn)
    write_taken_s |=> write_walk_s)
    else $error("write completion not signalled");
  write_once_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_done |=> !wr_done)
    else $error("write completion longer than one cycle");
  done_cause_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_done |-> $past(state_reg) == dcfs_pkg::DCFS_WRITE)
    else $error("write completion without a write");
  write_lands_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_reg == dcfs_pkg::DCFS_IDLE && wr_req && wr_index[2] && wr_src != 2'b11)
      |=> nv_cell[$past(wr_index[1:0])] == ($past(wr_cell) & $past(wr_data)))
    else $error("programming pattern not applied to the word");
  ignored_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_reg == dcfs_pkg::DCFS_IDLE && wr_req && (!wr_index[2] || wr_src == 2'b11))
      |=> nv_cell[$past(wr_index[1:0])] == $past(wr_cell))
    else $error("ignored write changed a stored word");
  bor_clear_only_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (bor_word & ~$past(bor_word)) == 16'h0000)
    else $error("a programmed bit returned to the erased state");
  state_legal_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $onehot(state_reg))
    else $error("store state is not one-hot");

  // Settings: erased defaults in reset, one load as reset ends, then held.
  reset_values_a: assert property (@(posedge core_clk)
    !resetn |=> (reset_pin_enable && pwm_pin_reset_mode && high_side_polarity
      && low_side_polarity && brownout_reset_enable
      && brownout_trip_select == 2'b11 && poweron_delay_select == 2'b11))
    else $error("settings not at erased defaults during reset");
  load_step_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == dcfs_pkg::DCFS_LOAD |=> state_reg == dcfs_pkg::DCFS_IDLE)
    else $error("load state lasted more than one cycle");
  reset_pin_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == dcfs_pkg::DCFS_LOAD
      |=> reset_pin_enable == $past(bor_word[`DCFS_BIT_RESET_PIN]))
    else $error("reset pin enable not loaded from stored word");
  pwm_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == dcfs_pkg::DCFS_LOAD
      |=> pwm_pin_reset_mode == $past(bor_word[`DCFS_BIT_PWM_MODE])
      && high_side_polarity == $past(bor_word[`DCFS_BIT_HIGH_POL]))
    else $error("pwm settings not loaded");
  pol_low_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == dcfs_pkg::DCFS_LOAD
      |=> low_side_polarity == $past(bor_word[`DCFS_BIT_LOW_POL]))
    else $error("low side polarity not loaded");
  brownout_reset_enable_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == dcfs_pkg::DCFS_LOAD
      |=> brownout_reset_enable == $past(bor_word[`DCFS_BIT_BOR_EN]))
    else $error("brown-out enable not loaded");
  trip_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == dcfs_pkg::DCFS_LOAD
      |=> brownout_trip_select == $past(bor_word[`DCFS_BROWNOUT_TRIP_SELECT_HI:`DCFS_BROWNOUT_TRIP_SELECT_LO]))
    else $error("brown-out trip select not loaded");
  poweron_delay_timer_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == dcfs_pkg::DCFS_LOAD
      |=> poweron_delay_select == $past(bor_word[`DCFS_POWERON_DELAY_TIMER_HI:`DCFS_POWERON_DELAY_TIMER_LO]))
    else $error("power-on delay select not loaded");
  settings_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg != dcfs_pkg::DCFS_LOAD |=> $stable({reset_pin_enable, pwm_pin_reset_mode,
      high_side_polarity, low_side_polarity, brownout_reset_enable, brownout_trip_select}))
    else $error("settings changed outside reset load");
  poweron_delay_timer_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg != dcfs_pkg::DCFS_LOAD |=> $stable(poweron_delay_select))
    else $error("power-on delay changed outside reset load");
endmodule // dcfs_store
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking testbench for the device configuration store.
`include "dcfs_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        rd_req   = 1'b0;
  logic [23:0] rd_addr  = 24'h00_0000;
  logic        rd_valid;
  logic [23:0] rd_data;
  logic        wr_req   = 1'b0;
  logic [1:0]  wr_src   = 2'h0;
  logic [23:0] wr_addr  = 24'h00_0000;
  logic [15:0] wr_data  = 16'h0000;
  logic        wr_done;
  wire  logic [8:0] cfg;
  logic [8:0]  cfg_exp  = 9'h1FF;
  logic [15:0] ex [4];
  logic [23:0] map [4] = '{`DCFS_ADDR_OSC, `DCFS_ADDR_WDT, `DCFS_ADDR_BOR, `DCFS_ADDR_CODE};
  logic [15:0] pat [4] = '{16'hFFFE, 16'hFF0F, 16'h7ADE, 16'h0000};
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  always #2 core_clk = ~core_clk;
  dcfs_store dcfs_store_inst (.core_clk(core_clk), .resetn(resetn), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .wr_req(wr_req),
    .wr_src(wr_src), .wr_addr(wr_addr), .wr_data(wr_data), .wr_done(wr_done),
    .reset_pin_enable(cfg[8]), .pwm_pin_reset_mode(cfg[7]), .high_side_polarity(cfg[6]),
    .low_side_polarity(cfg[5]), .brownout_reset_enable(cfg[4]),
    .brownout_trip_select(cfg[3:2]), .poweron_delay_select(cfg[1:0]));
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [23:0] a, input logic [23:0] exp);
    rd_req  = 1'b1;
    rd_addr = a;
    @(negedge core_clk);
    chk("rd_valid", 24'h00_0001, {23'h00_0000, rd_valid});
    chk("rd_data", exp, rd_data);
    rd_req = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic wr(input logic [1:0] s, input logic [23:0] a, input logic [15:0] d);
    wr_req  = 1'b1;
    wr_src  = s;
    wr_addr = a;
    wr_data = d;
    @(negedge core_clk);
    wr_req = 1'b0;
    @(negedge core_clk);
    chk("wr_done", 24'h00_0001, {23'h00_0000, wr_done});
    for (int k = 0; k < 4; k++) if (map[k] == a && s != 2'h3) ex[k] = ex[k] & d;
    @(negedge core_clk);
  endtask
  task automatic rd_all(input string name);
    logic [23:0] exp_word;
    for (int k = 0; k < 4; k++) begin
      exp_word = {8'h00, ex[k] & ((k == 2) ? `DCFS_BOR_IMPL_MASK : `DCFS_ERASED)};
      rd(map[k], exp_word);
    end
    rd(24'hF8_0006, 24'h00_0000);
    chk("settings_hold", {15'h0000, cfg_exp}, {15'h0000, cfg});
    $display("test %s done", name);
  endtask
  // Settings are taken from the stored word only as reset is released.
  task automatic do_reset();
    resetn = 1'b0;
    repeat (6) @(negedge core_clk);
    chk("reset_settings", 24'h00_01FF, {15'h0000, cfg});
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    cfg_exp = {ex[2][15], ex[2][10:7], ex[2][5:4], ex[2][1:0]};
    chk("settings", {15'h0000, cfg_exp}, {15'h0000, cfg});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    foreach (ex[k]) ex[k] = `DCFS_ERASED;
    @(negedge core_clk);
    do_reset();
    rd_all("erased_read");
    for (int s = 0; s < 4; s++) wr(s[1:0], map[s], pat[s]);
    wr(2'h0, 24'hF8_0008, 16'h0000);
    rd_all("program_sources");
    do_reset();
    wr(2'h1, `DCFS_ADDR_BOR, 16'hFD6D);
    rd_all("second_program");
    do_reset();
    $display("test settings_reload done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
